// file: include/dor_pkg.sv
// constants, types and helpers shared by the output-correction register block
`default_nettype none
package dor_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADR_W = 14;
    localparam int IDX_W = 12;
    localparam int DAT_W = 32;
    localparam int IDX_LSB = 2;

    // ****************************************
    // register indices (byte address = 4 * index)
    // ****************************************
    localparam logic [IDX_W-1:0] IDX_COARSE_B = 12'h726;
    localparam logic [IDX_W-1:0] IDX_ADJUST = 12'h727;
    localparam logic [IDX_W-1:0] IDX_SHUF_DITH = 12'h729;
    localparam logic [IDX_W-1:0] IDX_OFS0 = 12'h72a;
    localparam logic [IDX_W-1:0] IDX_OFS1 = 12'h72b;
    localparam logic [IDX_W-1:0] IDX_DP_CTRL = 12'h730;
    localparam logic [IDX_W-1:0] IDX_STATUS = 12'h731;
    localparam logic [IDX_W-1:0] IDX_APPLIED = 12'h732;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [7:0] RST_COARSE_B = 8'h0f;
    localparam logic [7:0] RST_ADJUST = 8'h11;
    localparam logic [7:0] RST_SHUF_DITH = 8'h00;
    localparam logic [15:0] RST_OFS = 16'h0000;
    localparam logic [1:0] RST_CTRL = 2'h0;
    localparam logic [2:0] RST_STATUS = 3'h0;

    // ****************************************
    // field layout
    // ****************************************
    localparam int CODE_W = 4;
    localparam int COARSE_LSB = 0;
    localparam int SLEEP_LSB = 4;
    localparam int ADJ0_LSB = 0;
    localparam int ADJ1_LSB = 4;
    localparam int NOISE_A_LSB = 0;
    localparam int NOISE_B_LSB = 2;
    localparam int SHUF_A_LSB = 4;
    localparam int SHUF_B_LSB = 6;
    localparam int MODE_W = 2;
    localparam int OFS_W = 13;
    localparam int SAMP_W = 16;
    localparam int CTRL_DATAPATH_ENABLE_BIT = 0;
    localparam int CTRL_BLK_BIT = 1;
    localparam int ST_SAT0_BIT = 0;
    localparam int ST_SAT1_BIT = 1;
    localparam int ST_HAZ_BIT = 2;
    localparam int APPLIED1_LSB = 16;

    // ****************************************
    // offset clamp and sample saturation limits
    // ****************************************
    localparam logic signed [OFS_W-1:0] OFS_LIM_DITHER = 13'sh0080;
    localparam logic signed [OFS_W-1:0] OFS_LIM_PLAIN = 13'sh0f80;
    localparam logic signed [SAMP_W:0] SAMP_MAX = 17'sh07fff;
    localparam logic signed [SAMP_W:0] SAMP_MIN = -17'sh08000;

    // ****************************************
    // modes and carriers
    // ****************************************
    typedef enum logic [1:0] {
        SHUF_SINGLE,
        SHUF_DUAL,
        SHUF_DATA,
        SHUF_OFF
    } dor_shuffle_e;

    typedef enum logic [1:0] {
        NOISE_SINGLE,
        NOISE_DUAL,
        NOISE_RSVD,
        NOISE_OFF
    } dor_noise_e;

    typedef struct packed {
        dor_shuffle_e shuffle_mode;
        logic [CODE_W-1:0] shuffle_adjust;
        dor_noise_e noise_mode;
    } dor_chan_cfg_s;

    // byte lane merge for partial writes
    function automatic logic [7:0] dor_lane(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic en);
        dor_lane = en ? new_v : old_v;
    endfunction

    // reserved dither code counts as dithering on
    function automatic logic dor_dither_on(input logic [MODE_W-1:0] m);
        dor_dither_on = (m != NOISE_OFF);
    endfunction

endpackage
`default_nettype wire

// file: rtl/dor_bias_sel.sv
// coarse bias code selector for the second channel, awake or asleep
`default_nettype none
module dor_bias_sel
    import dor_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sleep_i,
    input wire logic [CODE_W-1:0] run_code_i,
    input wire logic [CODE_W-1:0] sleep_code_i,
    output logic [CODE_W-1:0] code_o
);

    wire [CODE_W-1:0] code_next = sleep_i ? sleep_code_i : run_code_i;
    logic [CODE_W-1:0] code_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            code_reg <= RST_COARSE_B[COARSE_LSB +: CODE_W];
        end else begin
            code_reg <= code_next;
        end
    end

    assign code_o = code_reg;

endmodule
`default_nettype wire

// file: rtl/dor_chan_path.sv
// one channel: offset clamp, offset add, output saturation and gating
`default_nettype none
module dor_chan_path
    import dor_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic en_i,
    input wire logic valid_i,
    input wire logic [SAMP_W-1:0] sample_i,
    input wire logic [OFS_W-1:0] offset_i,
    input wire logic dither_i,
    output logic [SAMP_W-1:0] sample_o,
    output logic valid_o,
    output logic sat_o
);

    // ****************************************
    // offset clamp
    // ****************************************
    wire signed [OFS_W-1:0] ofs = signed'(offset_i);
    wire signed [OFS_W-1:0] lim = dither_i ? OFS_LIM_DITHER : OFS_LIM_PLAIN;
    wire ofs_hi = ofs > lim;
    wire ofs_lo = ofs < -lim;
    wire signed [OFS_W-1:0] ofs_cl = ofs_hi ? lim : (ofs_lo ? -lim : ofs);

    // ****************************************
    // add and saturate to the converter width
    // ****************************************
    // both operands sign-extended to the sum width on purpose
    wire signed [SAMP_W:0] sum = (SAMP_W+1)'(signed'(sample_i)) + (SAMP_W+1)'(ofs_cl);
    wire sum_hi = sum > SAMP_MAX;
    wire sum_lo = sum < SAMP_MIN;
    wire [SAMP_W-1:0] out_v = sum_hi ? SAMP_MAX[SAMP_W-1:0] :
                              (sum_lo ? SAMP_MIN[SAMP_W-1:0] : sum[SAMP_W-1:0]);
    wire take = en_i & valid_i;

    logic [SAMP_W-1:0] sample_reg;
    logic valid_reg;
    logic sat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            sample_reg <= '0;
            valid_reg <= 1'b0;
            sat_reg <= 1'b0;
        end else begin
            valid_reg <= take;
            sat_reg <= take & (ofs_hi | ofs_lo | sum_hi | sum_lo);
            if (take) begin
                sample_reg <= out_v;
            end
        end
    end

    assign sample_o = sample_reg;
    assign valid_o = valid_reg;
    assign sat_o = sat_reg;

endmodule
`default_nettype wire

// file: rtl/dor_regs.sv
// output-correction register bank with wishbone slave and two channel paths
//
// What this block does
// - a 4-bit coarse bias code for channel b sits in bits 3..0 and resets to all ones.
// - bits 7..4 hold the coarse bias code that channel b uses while asleep.
// - each channel has a 4-bit shuffle adjust, reset 1, used only in single-edge shuffling.
// - each 2-bit shuffle mode picks single-edge, dual-edge, data-dependent or off; reset 0.
// - each 2-bit dither field picks single-edge, dual-edge or off, 2 reserved; reset 0.
// - the offset in bits 12..0 is added to the channel samples; bits 15..13 are spare.
// - the offset is a signed 13-bit two's-complement value in converter steps.
// - with dithering on, the offset is clamped to plus or minus 128 before use.
// - with dithering off, the offset is clamped to plus or minus 3968 before use.
// - two 16-bit offset registers, channel zero lowest, both reset to zero.
// - samples reach the channels only while the datapath enable is set.
`default_nettype none
module dor_regs
    import dor_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,

    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [DAT_W-1:0] dat_i,
    input wire logic [3:0] sel_i,
    output logic [DAT_W-1:0] dat_o,
    output logic ack_o,

    input wire logic sleep_i,
    input wire logic samp_valid_i,
    input wire logic [SAMP_W-1:0] samp0_i,
    input wire logic [SAMP_W-1:0] samp1_i,
    output logic [SAMP_W-1:0] samp0_o,
    output logic [SAMP_W-1:0] samp1_o,
    output logic samp_valid_o,

    output logic [CODE_W-1:0] chan_b_bias_code_o,
    output dor_chan_cfg_s chan_a_cfg_o,
    output dor_chan_cfg_s chan_b_cfg_o
);

    // ****************************************
    // bus decode
    // ****************************************
    logic ack_reg;
    logic [DAT_W-1:0] dat_reg;

    // one wait state: ack follows the request edge and drops next cycle
    wire bus_req = cyc_i & stb_i & ~ack_reg;
    wire [IDX_W-1:0] idx = adr_i[IDX_LSB +: IDX_W];
    wire wr = bus_req & we_i;
    wire rd = bus_req & ~we_i;

    wire hit_coarse = (idx == IDX_COARSE_B);
    wire hit_adjust = (idx == IDX_ADJUST);
    wire hit_sd = (idx == IDX_SHUF_DITH);
    wire hit_ofs0 = (idx == IDX_OFS0);
    wire hit_ofs1 = (idx == IDX_OFS1);
    wire hit_ctrl = (idx == IDX_DP_CTRL);
    wire hit_status = (idx == IDX_STATUS);
    wire hit_applied = (idx == IDX_APPLIED);

    wire wr_coarse = wr & hit_coarse;
    wire wr_adjust = wr & hit_adjust;
    wire wr_sd = wr & hit_sd;
    wire wr_ofs0 = wr & hit_ofs0;
    wire wr_ofs1 = wr & hit_ofs1;
    wire wr_ctrl = wr & hit_ctrl;
    wire wr_status = wr & hit_status;

    // ****************************************
    // storage
    // ****************************************
    logic [7:0] coarse_reg;
    logic [7:0] adjust_reg;
    logic [7:0] sd_reg;
    logic [15:0] ofs0_reg;
    logic [15:0] ofs1_reg;
    logic [1:0] ctrl_reg;
    logic [2:0] status_reg;
    logic [OFS_W-1:0] shadow0_reg;
    logic [OFS_W-1:0] shadow1_reg;

    wire [7:0] coarse_next = dor_lane(coarse_reg, dat_i[7:0], sel_i[0]);
    wire [7:0] adjust_next = dor_lane(adjust_reg, dat_i[7:0], sel_i[0]);
    wire [7:0] sd_next = dor_lane(sd_reg, dat_i[7:0], sel_i[0]);
    wire [15:0] ofs0_next = {dor_lane(ofs0_reg[15:8], dat_i[15:8], sel_i[1]),
                             dor_lane(ofs0_reg[7:0], dat_i[7:0], sel_i[0])};
    wire [15:0] ofs1_next = {dor_lane(ofs1_reg[15:8], dat_i[15:8], sel_i[1]),
                             dor_lane(ofs1_reg[7:0], dat_i[7:0], sel_i[0])};
    wire [1:0] ctrl_next = sel_i[0] ? dat_i[1:0] : ctrl_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            coarse_reg <= RST_COARSE_B;
            adjust_reg <= RST_ADJUST;
            sd_reg <= RST_SHUF_DITH;
            ofs0_reg <= RST_OFS;
            ofs1_reg <= RST_OFS;
            ctrl_reg <= RST_CTRL;
        end else begin
            if (wr_coarse) begin
                coarse_reg <= coarse_next;
            end
            if (wr_adjust) begin
                adjust_reg <= adjust_next;
            end
            if (wr_sd) begin
                sd_reg <= sd_next;
            end
            if (wr_ofs0) begin
                ofs0_reg <= ofs0_next;
            end
            if (wr_ofs1) begin
                ofs1_reg <= ofs1_next;
            end
            if (wr_ctrl) begin
                ctrl_reg <= ctrl_next;
            end
        end
    end

    // ****************************************
    // control fields
    // ****************************************
    wire datapath_enable = ctrl_reg[CTRL_DATAPATH_ENABLE_BIT];
    wire chg_blk = ctrl_reg[CTRL_BLK_BIT];
    wire [MODE_W-1:0] shuf_a = sd_reg[SHUF_A_LSB +: MODE_W];
    wire [MODE_W-1:0] shuf_b = sd_reg[SHUF_B_LSB +: MODE_W];
    wire [MODE_W-1:0] noise_a = sd_reg[NOISE_A_LSB +: MODE_W];
    wire [MODE_W-1:0] noise_b = sd_reg[NOISE_B_LSB +: MODE_W];
    wire [CODE_W-1:0] adj0 = adjust_reg[ADJ0_LSB +: CODE_W];
    wire [CODE_W-1:0] adj1 = adjust_reg[ADJ1_LSB +: CODE_W];

    // ****************************************
    // applied offsets
    // ****************************************
    // the shadow copy moves only at a sample edge and only as a whole
    // word, so the path never sees a half-written offset
    wire shadow_load = samp_valid_i & ~chg_blk;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            shadow0_reg <= RST_OFS[OFS_W-1:0];
            shadow1_reg <= RST_OFS[OFS_W-1:0];
        end else if (shadow_load) begin
            shadow0_reg <= ofs0_reg[OFS_W-1:0];
            shadow1_reg <= ofs1_reg[OFS_W-1:0];
        end
    end

    // ****************************************
    // channel paths
    // ****************************************
    logic sat0;
    logic sat1;
    logic valid0;

    dor_chan_path u_path0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(datapath_enable),
        .valid_i(samp_valid_i),
        .sample_i(samp0_i),
        .offset_i(shadow0_reg),
        .dither_i(dor_dither_on(noise_a)),
        .sample_o(samp0_o),
        .valid_o(valid0),
        .sat_o(sat0)
    );

    dor_chan_path u_path1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(datapath_enable),
        .valid_i(samp_valid_i),
        .sample_i(samp1_i),
        .offset_i(shadow1_reg),
        .dither_i(dor_dither_on(noise_b)),
        .sample_o(samp1_o),
        .valid_o(),
        .sat_o(sat1)
    );

    assign samp_valid_o = valid0;

    // ****************************************
    // sticky status
    // ****************************************
    // hazard flags an offset write made while the path runs unblocked;
    // the write still lands, software is told and must clean up
    wire haz_ev = (wr_ofs0 | wr_ofs1) & datapath_enable & ~chg_blk;
    wire [2:0] st_set = {haz_ev, sat1, sat0};
    wire [2:0] st_clr = (wr_status & sel_i[0]) ? dat_i[2:0] : 3'h0;
    // set beats clear when both land in one cycle
    wire [2:0] status_next = (status_reg & ~st_clr) | st_set;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_reg <= RST_STATUS;
        end else begin
            status_reg <= status_next;
        end
    end

    // ****************************************
    // bias and mode outputs
    // ****************************************
    dor_bias_sel u_bias (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sleep_i(sleep_i),
        .run_code_i(coarse_reg[COARSE_LSB +: CODE_W]),
        .sleep_code_i(coarse_reg[SLEEP_LSB +: CODE_W]),
        .code_o(chan_b_bias_code_o)
    );

    // adjust is forced to zero outside single-edge shuffling
    wire [CODE_W-1:0] eff_adj0 = (shuf_a == SHUF_SINGLE) ? adj0 : '0;
    wire [CODE_W-1:0] eff_adj1 = (shuf_b == SHUF_SINGLE) ? adj1 : '0;

    dor_chan_cfg_s cfg_a_reg;
    dor_chan_cfg_s cfg_b_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_a_reg <= '0;
            cfg_b_reg <= '0;
        end else begin
            cfg_a_reg <= '{dor_shuffle_e'(shuf_a), eff_adj0, dor_noise_e'(noise_a)};
            cfg_b_reg <= '{dor_shuffle_e'(shuf_b), eff_adj1, dor_noise_e'(noise_b)};
        end
    end

    assign chan_a_cfg_o = cfg_a_reg;
    assign chan_b_cfg_o = cfg_b_reg;

    // ****************************************
    // read mux and answer
    // ****************************************
    // unmapped indices answer with ack and zero data
    wire [DAT_W-1:0] rd_data =
        hit_coarse ? {24'h0, coarse_reg} :
        hit_adjust ? {24'h0, adjust_reg} :
        hit_sd ? {24'h0, sd_reg} :
        hit_ofs0 ? {16'h0, ofs0_reg} :
        hit_ofs1 ? {16'h0, ofs1_reg} :
        hit_ctrl ? {30'h0, ctrl_reg} :
        hit_status ? {29'h0, status_reg} :
        hit_applied ? {3'h0, shadow1_reg, 3'h0, shadow0_reg} :
        32'h0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            if (rd) begin
                dat_reg <= rd_data;
            end
        end
    end

    assign ack_o = ack_reg;
    assign dat_o = dat_reg;

endmodule
`default_nettype wire

// file: tb/dor_regs_monitor.sv
// assertion checker for the output-correction register block
`default_nettype none
module dor_regs_monitor
    import dor_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [DAT_W-1:0] dat_i,
    input wire logic [3:0] sel_i,
    input wire logic ack_o,
    input wire logic sleep_i,
    input wire logic samp_valid_i,
    input wire logic [SAMP_W-1:0] samp0_i,
    input wire logic [SAMP_W-1:0] samp1_i,
    input wire logic [SAMP_W-1:0] samp0_o,
    input wire logic [SAMP_W-1:0] samp1_o,
    input wire logic samp_valid_o,
    input wire logic [CODE_W-1:0] chan_b_bias_code_o,
    input wire dor_chan_cfg_s chan_a_cfg_o,
    input wire dor_chan_cfg_s chan_b_cfg_o
);
    // ****************************************
    // mirror of bus writes, lane 0 only
    // ****************************************
    logic [7:0] bias_reg, adj_reg, mode_reg;
    logic dp_reg;
    wire logic [IDX_W-1:0] idx = adr_i[ADR_W-1:IDX_LSB];
    wire logic wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
    wire logic [3:0] bias_exp = sleep_i ? bias_reg[7:4] : bias_reg[3:0];
    wire logic [3:0] adj_a = (mode_reg[5:4] == 2'h0) ? adj_reg[3:0] : 4'h0;
    wire logic [3:0] adj_b = (mode_reg[7:6] == 2'h0) ? adj_reg[7:4] : 4'h0;
    wire logic [7:0] cfg_a_exp = {mode_reg[5:4], adj_a, mode_reg[1:0]};
    wire logic [7:0] cfg_b_exp = {mode_reg[7:6], adj_b, mode_reg[3:2]};
    wire logic take_s = samp_valid_i && dp_reg;
    wire logic dith_a = mode_reg[1:0] != 2'h3;
    wire logic dith_b = mode_reg[3:2] != 2'h3;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bias_reg <= 8'h0f;
            adj_reg <= 8'h11;
            mode_reg <= 8'h00;
            dp_reg <= 1'b0;
        end else if (wr_take) begin
            if (idx == IDX_COARSE_B) bias_reg <= dat_i[7:0];
            if (idx == IDX_ADJUST) adj_reg <= dat_i[7:0];
            if (idx == IDX_SHUF_DITH) mode_reg <= dat_i[7:0];
            if (idx == IDX_DP_CTRL) dp_reg <= dat_i[0];
        end
    end

    // saturation only shrinks the step, so a bound is safe
    function automatic bit near(input logic [15:0] o, input logic [15:0] i, input int lim);
        int d;
        d = int'($signed(o)) - int'($signed(i));
        return (d <= lim) && (d >= -lim);
    endfunction

    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("bus request not answered next cycle");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    AST_BIAS: assert property (!$past(rst_i) |-> chan_b_bias_code_o == $past(bias_exp))
        else $error("bias code wrong");
    AST_CFG_A: assert property (!$past(rst_i) |-> chan_a_cfg_o == $past(cfg_a_exp))
        else $error("channel a config wrong");
    AST_CFG_B: assert property (!$past(rst_i) |-> chan_b_cfg_o == $past(cfg_b_exp))
        else $error("channel b config wrong");
    AST_GATE: assert property (!$past(dp_reg) |-> !samp_valid_o && !samp0_o && !samp1_o)
        else $error("samples pass while disabled");
    AST_VALID: assert property (!$past(rst_i) |-> samp_valid_o == $past(take_s))
        else $error("output strobe wrong");
    AST_WIDE: assert property (samp_valid_o |-> near(samp0_o, $past(samp0_i), 3968)
        && near(samp1_o, $past(samp1_i), 3968))
        else $error("offset beyond wide limit");
    AST_NARROW: assert property (samp_valid_o |->
        (!$past(dith_a) || near(samp0_o, $past(samp0_i), 128))
        && (!$past(dith_b) || near(samp1_o, $past(samp1_i), 128)))
        else $error("offset beyond dither limit");
endmodule

bind dor_regs dor_regs_monitor dor_regs_monitor_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .ack_o, .sleep_i,
    .samp_valid_i, .samp0_i, .samp1_i, .samp0_o, .samp1_o, .samp_valid_o,
    .chan_b_bias_code_o, .chan_a_cfg_o, .chan_b_cfg_o
);
`default_nettype wire

// file: tb/dor_regs_tb_top.sv
// self-checking bench for the output-correction register block
`default_nettype none
module dor_regs_tb_top;
    import dor_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // stimulus, design and model state
    // ****************************************
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic sleep_i = 1'b0, samp_valid_i = 1'b0, ack_o, samp_valid_o;
    logic [ADR_W-1:0] adr_i = 14'h0000;
    logic [DAT_W-1:0] dat_i = 32'h0000_0000, dat_o;
    logic [3:0] sel_i = 4'h0;
    logic [SAMP_W-1:0] samp0_i = 16'h0000, samp1_i = 16'h0000, samp0_o, samp1_o;
    logic [CODE_W-1:0] chan_b_bias_code_o;
    dor_chan_cfg_s chan_a_cfg_o, chan_b_cfg_o;
    int failures = 0, samples_checked = 0;
    int ofs[2] = '{0, 0}, sh[2] = '{0, 0}, dm[2] = '{0, 0};
    bit dp = 1'b0, blk = 1'b0;

    dor_regs dor_regs_inst (
        .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i, .dat_o, .ack_o,
        .sleep_i, .samp_valid_i, .samp0_i, .samp1_i, .samp0_o, .samp1_o, .samp_valid_o,
        .chan_b_bias_code_o, .chan_a_cfg_o, .chan_b_cfg_o
    );

    always #10 clk_i = ~clk_i;

    function automatic int sx(input logic [15:0] v);
        return v[12] ? int'(v[12:0]) - 8192 : int'(v[12:0]);
    endfunction

    function automatic logic [7:0] cfgx(input logic [1:0] m, input logic [3:0] a,
                                        input logic [1:0] n);
        return {m, (m == 2'h0) ? a : 4'h0, n};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // holds the request until ack is sampled high
    task automatic wb(input logic w, input logic [IDX_W-1:0] ix, input logic [15:0] d,
                      output logic [DAT_W-1:0] q);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {ix, 2'h0};
        dat_i <= {16'h0000, d};
        sel_i <= 4'h3;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 50) begin
            @(posedge clk_i);
            n++;
        end
        if (ack_o !== 1'b1) begin
            failures++;
            $display("ERROR %0t bus answer missing", $time);
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [IDX_W-1:0] ix, input logic [15:0] d);
        logic [DAT_W-1:0] q;
        wb(1'b1, ix, d, q);
        if (ix == IDX_OFS0) ofs[0] = sx(d);
        if (ix == IDX_OFS1) ofs[1] = sx(d);
        if (ix == IDX_DP_CTRL) dp = d[0];
        if (ix == IDX_DP_CTRL) blk = d[1];
    endtask

    task automatic rd(input logic [IDX_W-1:0] ix, input logic [31:0] e);
        logic [DAT_W-1:0] q;
        wb(1'b0, ix, 16'h0000, q);
        chk(q, e);
    endtask

    // the sample uses the old shadow; the shadow reloads at the same edge
    task automatic samp(input bit c);
        logic [15:0] a[2];
        int e, v, lim;
        for (int j = 0; j < 2; j++) begin
            a[j] = 16'($urandom);
            if ($urandom_range(3) == 0) a[j] = a[j][0] ? 16'h7ff0 : 16'h8010;
        end
        samp_valid_i <= 1'b1;
        samp0_i <= a[0];
        samp1_i <= a[1];
        @(posedge clk_i);
        samp_valid_i <= 1'b0;
        @(posedge clk_i);
        for (int j = 0; j < 2; j++) begin
            lim = (dm[j] == 3) ? 3968 : 128;
            v = (sh[j] > lim) ? lim : (sh[j] < -lim) ? -lim : sh[j];
            e = dp ? int'($signed(a[j])) + v : 0;
            e = (e > 32767) ? 32767 : (e < -32768) ? -32768 : e;
            if (c) chk(j ? samp1_o : samp0_o, {16'h0000, 16'(e)});
            // shadow reloads on every strobe unless blocked, enabled or not
            if (!blk) sh[j] = ofs[j];
        end
        if (c) chk(samp_valid_o, dp);
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        logic [7:0] d, adj, val;
        logic [15:0] ot[11];
        ot = '{16'h007f, 16'h0080, 16'h1f80, 16'h1f7f, 16'h0f80, 16'h0f81,
               16'h1080, 16'h107f, 16'h0fff, 16'h1000, 16'he000};
        void'($urandom(19721));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(IDX_COARSE_B, 32'h0000_000f);
        rd(IDX_ADJUST, 32'h0000_0011);
        rd(IDX_SHUF_DITH, 32'h0000_0000);
        rd(IDX_OFS0, 32'h0000_0000);
        rd(IDX_OFS1, 32'h0000_0000);
        rd(12'h7ff, 32'h0000_0000);
        chk(32'(chan_b_bias_code_o), 32'h0000_000f);
        chk(32'(chan_a_cfg_o), 32'(cfgx(2'h0, 4'h1, 2'h0)));
        for (int i = 0; i < 16; i++) begin
            d = 8'($urandom);
            adj = {2'h0, 2'($urandom), 2'h0, 2'($urandom)};
            val = {i[1:0], i[3:2], i[1:0], i[3:2]};
            sleep_i <= i[0];
            wr(IDX_COARSE_B, {8'h00, d});
            wr(IDX_ADJUST, {8'h00, adj});
            wr(IDX_SHUF_DITH, {8'h00, val});
            rd(IDX_SHUF_DITH, {24'h00_0000, val});
            chk(32'(chan_b_bias_code_o), 32'(i[0] ? d[7:4] : d[3:0]));
            chk(32'(chan_a_cfg_o), 32'(cfgx(val[5:4], adj[3:0], val[1:0])));
            chk(32'(chan_b_cfg_o), 32'(cfgx(val[7:6], adj[7:4], val[3:2])));
        end
        for (int t = 0; t < 4; t++) begin
            dm[0] = t;
            dm[1] = t;
            wr(IDX_SHUF_DITH, 16'(t * 5));
            for (int k = 0; k < 11; k++) begin
                wr(IDX_DP_CTRL, 16'h0000);
                wr(IDX_OFS0, ot[k]);
                wr(IDX_OFS1, ot[10 - k]);
                rd(IDX_OFS0, {16'h0000, ot[k]});
                samp(1'b1);
                wr(IDX_DP_CTRL, 16'h0001);
                samp(1'b0);
                samp(1'b1);
            end
        end
        wr(IDX_DP_CTRL, 16'h0003);
        wr(IDX_OFS0, 16'h0010);
        samp(1'b1);
        samp(1'b1);
        wr(IDX_DP_CTRL, 16'h0001);
        samp(1'b0);
        samp(1'b1);
        wr(IDX_STATUS, 16'h0007);
        rd(IDX_STATUS, 32'h0000_0000);
        rd(IDX_APPLIED, {3'h0, 13'(sh[1]), 3'h0, 13'(sh[0])});
        wr(IDX_OFS1, 16'h0000);
        rd(IDX_STATUS, 32'h0000_0004);
        finish_test();
    end

    initial begin
        #400us;
        failures++;
        $display("ERROR %0t watchdog expired", $time);
        finish_test();
    end
endmodule
`default_nettype wire
